// *** rtl/cmd_port_pkg.sv ***
// Constants, types and length tables for the serial register command port
package cmd_port_pkg;

  // ****************************************************************
  // Clock and serial timing
  // ****************************************************************
  localparam int unsigned CLK_HZ    = 50_000_000;
  localparam int unsigned BAUD_FAST = 115_200;
  localparam int unsigned BAUD_SLOW = 56_700;
  localparam int unsigned DIV_W     = 16;
  localparam logic [DIV_W-1:0] DIV_FAST = DIV_W'(CLK_HZ / BAUD_FAST);
  localparam logic [DIV_W-1:0] DIV_SLOW = DIV_W'(CLK_HZ / BAUD_SLOW);
  localparam int unsigned CHAR_BITS = 8;
  localparam logic [3:0]  TX_FRAME  = 4'hA;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int unsigned DATA_MAX  = 5;
  localparam int unsigned DATA_W    = DATA_MAX * CHAR_BITS;
  localparam logic [7:0]  ACK_BYTE  = 8'h02;
  localparam logic [7:0]  QUERY_LO  = 8'h20;
  localparam logic [7:0]  QUERY_HI  = 8'h26;
  localparam logic [2:0]  LEN_ONE   = 3'h1;
  localparam logic [2:0]  LEN_TWO   = 3'h2;
  localparam logic [2:0]  LEN_FOUR  = 3'h4;
  localparam logic [2:0]  LEN_FIVE  = 3'h5;

  typedef struct packed {
    logic [7:0]        addr;
    logic [DATA_W-1:0] data;
    logic [2:0]        len;
  } cmd_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_BITS,
    RX_STOP
  } rx_state_t;

  typedef enum logic [1:0] {
    C_ADDR,
    C_DATA,
    C_EXEC,
    C_RESP
  } cmd_state_t;

  function automatic logic is_query(input logic [7:0] addr);
    return (addr >= QUERY_LO) && (addr <= QUERY_HI);
  endfunction

  // Data bytes that follow an address byte; never fewer than one
  function automatic logic [2:0] data_len(input logic [7:0] addr);
    logic [2:0] n;
    n = LEN_ONE;
    if ((addr >= 8'h06 && addr <= 8'h08) || addr == 8'h0D) begin
      n = LEN_FIVE;
    end else if (addr >= 8'h09 && addr <= 8'h0C) begin
      n = LEN_FOUR;
    end
    return n;
  endfunction

  // Bytes returned by a query register, most significant first
  function automatic logic [2:0] resp_len(input logic [7:0] addr);
    logic [2:0] n;
    n = LEN_FIVE;
    if (addr == 8'h21 || addr == 8'h22 || addr == 8'h23) begin
      n = LEN_FOUR;
    end else if (addr == 8'h25) begin
      n = LEN_TWO;
    end
    return n;
  endfunction

endpackage

// *** rtl/serial_char_tx.sv ***
// Serial character transmitter, 8 data bits, no parity, one stop bit
`timescale 1ns/100ps
module serial_char_tx (
  // Clock and reset
  input  wire logic                           ref_clk_i,
  input  wire logic                           rst_i,
  // Rate and character
  input  wire logic [cmd_port_pkg::DIV_W-1:0] div_i,
  input  wire logic                           go_i,
  input  wire logic [7:0]                     char_i,
  // Line side
  output logic                                line_o,
  output logic                                busy_o
);

  logic [9:0]                     shift;
  logic [3:0]                     bits_left;
  logic [cmd_port_pkg::DIV_W-1:0] cnt;
  wire                            bit_end = (cnt == '0);

  // Start bit low, data LSB first, stop bit high [R9]
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift     <= 10'h3FF;
      bits_left <= 4'h0;
      cnt       <= '0;
      line_o    <= 1'b1;
      busy_o    <= 1'b0;
    end else if (!busy_o) begin
      if (go_i) begin
        shift     <= {1'b1, char_i, 1'b0};
        bits_left <= cmd_port_pkg::TX_FRAME;
        cnt       <= '0;
        busy_o    <= 1'b1;
      end
    end else if (bit_end) begin
      line_o    <= shift[0];
      shift     <= {1'b1, shift[9:1]};
      cnt       <= div_i - 1'b1;
      bits_left <= bits_left - 1'b1;
      busy_o    <= (bits_left != 4'h0);
    end else begin
      cnt <= cnt - 1'b1;
    end
  end

endmodule

// *** rtl/serial_command_port.sv ***
// Register command interpreter behind an asynchronous serial link
`timescale 1ns/100ps
// Behaviour
// R1 - Host sends address and every data byte, zeros included.
// R2 - After an address byte, collect all its data bytes before executing.
// R3 - Too few data bytes leave the port waiting until hardware reset.
// R4 - After a write command executes, send exactly one byte with bit 1 set.
// R5 - Host reads each acknowledge byte so later answers stay aligned.
// R6 - Acknowledge means ready; host waits for it before the next address.
// R7 - A query returns a fixed, register-specific number of response bytes.
// R8 - Host sends full data bytes for queries too before any answer.
// R9 - Characters are 8 data bits, no parity, one stop bit, no flow control.
// R10 - Baud select sampled at reset: low gives fast rate, high gives slow.
module serial_command_port (
  // Clock and reset
  input  wire logic                               ref_clk_i,
  input  wire logic                               rst_i,
  // Serial pins
  input  wire logic                               rx_pin_i,
  input  wire logic                               baud_sel_i,
  output logic                                    tx_pin_o,
  // Instrument core side
  output logic                                    cmd_valid_o,
  output cmd_port_pkg::cmd_t                      cmd_o,
  input  wire logic                               done_i,
  input  wire logic [cmd_port_pkg::DATA_W-1:0]    resp_i,
  output logic                                    busy_o
);

  // ****************************************************************
  // Pin synchronisers and rate capture
  // ****************************************************************
  logic [1:0]                     rx_sync;
  logic [1:0]                     sel_sync;
  logic                           rate_taken;
  logic [cmd_port_pkg::DIV_W-1:0] div;
  wire                            rx_line = rx_sync[1];

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_sync  <= 2'h3;
      sel_sync <= 2'h3;
    end else begin
      rx_sync  <= {rx_sync[0], rx_pin_i};
      sel_sync <= {sel_sync[0], baud_sel_i};
    end
  end

  // The pin is taken once after release; later changes need a new reset.
  // Two cycles after release the synchronised copy holds the real level.
  logic [1:0] settle;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      settle     <= 2'h0;
      rate_taken <= 1'b0;
      div        <= cmd_port_pkg::DIV_SLOW;
    end else if (!rate_taken) begin
      settle <= settle + 1'b1;
      if (settle == 2'h3) begin
        rate_taken <= 1'b1;
        div        <= sel_sync[1] ? cmd_port_pkg::DIV_SLOW
                                  : cmd_port_pkg::DIV_FAST; // [R10]
      end
    end
  end

  // ****************************************************************
  // Receiver
  // ****************************************************************
  cmd_port_pkg::rx_state_t        rx_state;
  logic [cmd_port_pkg::DIV_W-1:0] rx_cnt;
  logic [2:0]                     rx_bit;
  logic [7:0]                     rx_shift;
  logic                           rx_valid;
  wire                            rx_tick = (rx_cnt == '0);
  wire [cmd_port_pkg::DIV_W-1:0]  half_bit = {1'b0, div[cmd_port_pkg::DIV_W-1:1]};

  // Samples mid-bit; a low stop bit drops the character [R9]
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_state <= cmd_port_pkg::RX_IDLE;
      rx_cnt   <= '0;
      rx_bit   <= 3'h0;
      rx_shift <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (rx_state != cmd_port_pkg::RX_IDLE && !rx_tick) begin
        rx_cnt <= rx_cnt - 1'b1;
      end
      case (rx_state)
        cmd_port_pkg::RX_IDLE: begin
          if (rate_taken && !rx_line) begin
            rx_cnt   <= half_bit;
            rx_state <= cmd_port_pkg::RX_START;
          end
        end
        cmd_port_pkg::RX_START: begin
          if (rx_tick) begin
            rx_cnt   <= div - 1'b1;
            rx_bit   <= 3'h0;
            rx_state <= rx_line ? cmd_port_pkg::RX_IDLE : cmd_port_pkg::RX_BITS;
          end
        end
        cmd_port_pkg::RX_BITS: begin
          if (rx_tick) begin
            rx_cnt   <= div - 1'b1;
            rx_shift <= {rx_line, rx_shift[7:1]};
            rx_bit   <= rx_bit + 1'b1;
            if (rx_bit == 3'h7) begin
              rx_state <= cmd_port_pkg::RX_STOP;
            end
          end
        end
        cmd_port_pkg::RX_STOP: begin
          if (rx_tick) begin
            rx_valid <= rx_line;
            rx_state <= cmd_port_pkg::RX_IDLE;
          end
        end
        default: begin
          rx_state <= cmd_port_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  cmd_port_pkg::cmd_state_t       state;
  logic [2:0]                     bytes_left;
  logic [cmd_port_pkg::DATA_W-1:0] out_shift;
  logic                           tx_go;
  logic                           tx_busy;
  wire                            query = cmd_port_pkg::is_query(cmd_o.addr);
  wire                            tx_free = !tx_busy && !tx_go;
  wire [7:0]                      tx_char =
    out_shift[cmd_port_pkg::DATA_W-1 -: cmd_port_pkg::CHAR_BITS];

  // Bytes arriving outside address/data phases are dropped: the host
  // must wait for the acknowledge or answer before the next address.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state       <= cmd_port_pkg::C_ADDR;
      bytes_left  <= 3'h0;
      cmd_o       <= '0;
      cmd_valid_o <= 1'b0;
      out_shift   <= '0;
      tx_go       <= 1'b0;
      busy_o      <= 1'b0;
    end else begin
      cmd_valid_o <= 1'b0;
      tx_go       <= 1'b0;
      case (state)
        cmd_port_pkg::C_ADDR: begin
          busy_o <= 1'b0;
          if (rx_valid) begin
            cmd_o.addr <= rx_shift;
            cmd_o.data <= '0;
            cmd_o.len  <= cmd_port_pkg::data_len(rx_shift); // [R2]
            bytes_left <= cmd_port_pkg::data_len(rx_shift);
            busy_o     <= 1'b1;
            state      <= cmd_port_pkg::C_DATA;
          end
        end
        cmd_port_pkg::C_DATA: begin
          // No timeout: a short frame parks here until reset [R3]
          if (rx_valid) begin
            cmd_o.data <= {cmd_o.data[cmd_port_pkg::DATA_W-cmd_port_pkg::CHAR_BITS-1:0],
                           rx_shift};
            bytes_left <= bytes_left - 1'b1;
            if (bytes_left == cmd_port_pkg::LEN_ONE) begin
              cmd_valid_o <= 1'b1; // [R2]
              state       <= cmd_port_pkg::C_EXEC;
            end
          end
        end
        cmd_port_pkg::C_EXEC: begin
          if (done_i) begin
            if (query) begin
              out_shift  <= resp_i;
              bytes_left <= cmd_port_pkg::resp_len(cmd_o.addr); // [R7]
            end else begin
              out_shift  <= {cmd_port_pkg::ACK_BYTE,
                             {(cmd_port_pkg::DATA_W-8){1'b0}}}; // [R4]
              bytes_left <= cmd_port_pkg::LEN_ONE; // [R4]
            end
            state <= cmd_port_pkg::C_RESP;
          end
        end
        cmd_port_pkg::C_RESP: begin
          if (tx_free) begin
            if (bytes_left == 3'h0) begin
              state <= cmd_port_pkg::C_ADDR; // [R6]
            end else begin
              tx_go      <= 1'b1;
              out_shift  <= out_shift << cmd_port_pkg::CHAR_BITS;
              bytes_left <= bytes_left - 1'b1;
            end
          end
        end
        default: begin
          state <= cmd_port_pkg::C_ADDR;
        end
      endcase
    end
  end

  // The character is held in tx_hold on the edge that raises go, so the
  // shifted buffer can move on at once.
  logic [7:0] tx_hold;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_hold <= 8'h00;
    end else if (state == cmd_port_pkg::C_RESP && tx_free) begin
      tx_hold <= tx_char;
    end
  end

  serial_char_tx u_tx (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .div_i     (div),
    .go_i      (tx_go),
    .char_i    (tx_hold),
    .line_o    (tx_pin_o),
    .busy_o    (tx_busy)
  );

endmodule

// *** sim/serial_command_port_chk.sv ***
// Assertion checker for the serial command port
`timescale 1ns/100ps
module serial_command_port_chk (
  // Clock and reset
  input wire logic                            ref_clk_i,
  input wire logic                            rst_i,
  // Serial pins
  input wire logic                            rx_pin_i,
  input wire logic                            baud_sel_i,
  input wire logic                            tx_pin_o,
  // Core side
  input wire logic                            cmd_valid_o,
  input wire cmd_port_pkg::cmd_t              cmd_o,
  input wire logic                            done_i,
  input wire logic [cmd_port_pkg::DATA_W-1:0] resp_i,
  input wire logic                            busy_o
);
  // ****
  // Helper state
  // ****
  logic       exec;
  wire  [7:0] a = cmd_o.addr;
  wire  [2:0] exp_len = ((a >= 8'h06 && a <= 8'h08) || a == 8'h0D) ? 3'h5 :
                        (a >= 8'h09 && a <= 8'h0C) ? 3'h4 : 3'h1;
  // Set between a frame and its completion; no answer may leave then
  // The core may finish on the edge that still sees the valid pulse, so
  // the valid cycle itself counts as executing and a completion clears.
  wire  in_exec = cmd_valid_o || exec;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) exec <= 1'b0;
    else exec <= (exec || cmd_valid_o) && !done_i;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  AST_VALID_PULSE:
    assert property (cmd_valid_o |=> !cmd_valid_o) else $error("valid not a pulse");
  AST_LEN_MATCH:
    assert property (cmd_valid_o |-> cmd_o.len == exp_len) else $error("bad frame length");
  AST_BUSY_AT_VALID:
    assert property (cmd_valid_o |-> busy_o) else $error("not busy at frame");
  AST_BUSY_IN_EXEC:
    assert property (in_exec |-> busy_o) else $error("busy dropped while executing");
  AST_QUIET_IN_EXEC:
    assert property (in_exec && !done_i |-> tx_pin_o) else $error("answer before done");
  AST_START_AFTER_DONE:
    assert property (in_exec && done_i |-> ##[2:6] !tx_pin_o) else $error("no answer start");
  AST_IDLE_HIGH:
    assert property (!busy_o |-> tx_pin_o) else $error("line low while idle");
  AST_START_WIDTH:
    assert property ($fell(tx_pin_o) |=> !tx_pin_o [*8]) else $error("start bit short");
endmodule
bind serial_command_port serial_command_port_chk u_serial_command_port_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .rx_pin_i(rx_pin_i), .baud_sel_i(baud_sel_i),
  .tx_pin_o(tx_pin_o), .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .done_i(done_i),
  .resp_i(resp_i), .busy_o(busy_o));

// *** sim/host_serial_model.sv ***
// Host side of the serial link: sends and receives 8N1 characters
`timescale 1ns/100ps
module host_serial_model (
  // Clock
  input  wire logic ref_clk_i,
  // Line
  input  wire logic line_i,
  output logic      line_o
);
  // Idle line rests high, as a released line with pull-up would
  initial line_o = 1'b1;
  // Start, data LSB first, stop; bytes back to back, zeros sent too
  task automatic send_byte(input logic [cmd_port_pkg::DIV_W-1:0] div, input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk_i);
      #1 line_o = f[i];
      repeat (div - 1) @(posedge ref_clk_i);
    end
  endtask
  // Every answer byte is consumed before the next command
  task automatic recv_byte(input logic [cmd_port_pkg::DIV_W-1:0] div, output logic [7:0] b);
    int t;
    t = 0;
    while (line_i !== 1'b0 && t < 20000) begin
      @(negedge ref_clk_i);
      t++;
    end
    repeat (div / 2) @(negedge ref_clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(negedge ref_clk_i);
      b[i] = line_i;
    end
    repeat (div) @(negedge ref_clk_i);
  endtask
endmodule

// *** sim/serial_command_port_tb_top.sv ***
// Self-checking bench for the serial command port
`timescale 1ns/100ps
module serial_command_port_tb_top;
  logic                              ref_clk_i = 1'b0;
  logic                              rst_i = 1'b1;
  logic                              baud_sel_i = 1'b0;
  logic                              done_i = 1'b0;
  logic [cmd_port_pkg::DATA_W-1:0]   resp_i = '0;
  logic [cmd_port_pkg::DIV_W-1:0]    div = cmd_port_pkg::DIV_FAST;
  wire                               rx_pin_i;
  logic                              tx_pin_o;
  logic                              cmd_valid_o;
  logic                              busy_o;
  cmd_port_pkg::cmd_t                cmd_o;
  int                                bad_count = 0;
  int                                samples_checked = 0;
  int                                valid_seen = 0;
  logic [39:0]                       got;

  always #10 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (cmd_valid_o === 1'b1) valid_seen <= valid_seen + 1;

  serial_command_port u_serial_command_port (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .rx_pin_i(rx_pin_i), .baud_sel_i(baud_sel_i), .tx_pin_o(tx_pin_o),
    .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .done_i(done_i), .resp_i(resp_i),
    .busy_o(busy_o));
  host_serial_model u_host_serial_model (.ref_clk_i(ref_clk_i), .line_i(tx_pin_o),
    .line_o(rx_pin_i));

  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checked=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic do_reset(input logic sel);
    @(posedge ref_clk_i);
    #1 rst_i = 1'b1;
    baud_sel_i = sel;
    repeat (5) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    repeat (6) @(posedge ref_clk_i);
  endtask
  // Sends a whole frame, plays the core, collects nr answer bytes
  task automatic run_cmd(input logic [7:0] a, input logic [39:0] d, input int n,
                         input logic [39:0] rsp, input int nr);
    logic [7:0] b;
    int         t;
    got = '0;
    t = 0;
    fork
      begin
        u_host_serial_model.send_byte(div, a);
        for (int i = n - 1; i >= 0; i--) u_host_serial_model.send_byte(div, d[i*8 +: 8]);
      end
      begin
        do begin
          @(posedge ref_clk_i);
          #1 t++;
        end while (cmd_valid_o !== 1'b1 && t < 60000);
        check(cmd_o.addr, a);
        check(cmd_o.len, n);
        check(cmd_o.data, d);
        // The core takes a few cycles, so the quiet window is exercised
        repeat (3) @(posedge ref_clk_i);
        #1 done_i = 1'b1;
        resp_i = rsp;
        @(posedge ref_clk_i);
        #1 done_i = 1'b0;
        for (int i = 0; i < nr; i++) begin
          u_host_serial_model.recv_byte(div, b);
          got = {got[31:0], b};
        end
      end
    join
  endtask

  // ****
  // Scenarios
  // ****
  task automatic test_write_one;
    run_cmd(8'h01, 40'h5A, 1, 40'h0, 1);
    check(got[7:0], cmd_port_pkg::ACK_BYTE);
    repeat (div) @(negedge ref_clk_i);
    check(busy_o, 1'b0);
    $display("test_write_one done");
  endtask
  task automatic test_write_four;
    run_cmd(8'h09, 40'h11223344, 4, 40'h0, 1);
    check(got[7:0], cmd_port_pkg::ACK_BYTE);
    $display("test_write_four done");
  endtask
  task automatic test_query;
    run_cmd(8'h25, 40'h0, 1, 40'hA1B2C3D4E5, 2);
    check(got[15:0], 16'hA1B2);
    repeat (div) @(negedge ref_clk_i);
    check(busy_o, 1'b0);
    check(tx_pin_o, 1'b1);
    $display("test_query done");
  endtask
  task automatic test_short_frame;
    int v;
    v = valid_seen;
    u_host_serial_model.send_byte(div, 8'h06);
    u_host_serial_model.send_byte(div, 8'h77);
    repeat (6 * div) @(negedge ref_clk_i);
    check(valid_seen, v);
    check(busy_o, 1'b1);
    do_reset(1'b0);
    check(busy_o, 1'b0);
    $display("test_short_frame done");
  endtask
  task automatic test_slow_rate;
    do_reset(1'b1);
    div = cmd_port_pkg::DIV_SLOW;
    run_cmd(8'h01, 40'h33, 1, 40'h0, 1);
    check(got[7:0], cmd_port_pkg::ACK_BYTE);
    $display("test_slow_rate done");
  endtask

  initial begin
    do_reset(1'b0);
    test_write_one();
    test_write_four();
    test_query();
    test_short_frame();
    test_slow_rate();
    report_and_stop();
  end
  // Expected run is about 93k cycles
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    bad_count++;
    report_and_stop();
  end
endmodule
